// >>> lrb_pkg.sv
// Package of constants and types for the display memory and multiplex drive block.
package lrb_pkg;
	localparam int LRB_COLS = 160;
	localparam int LRB_ROWS = 4;
	localparam int LRB_PTR_W = 8;
	localparam logic [7:0] LRB_LAST_COL = 8'h9f;
	// Drive mode codes as carried by the configuration inputs.
	localparam logic [1:0] LRB_MODE_STATIC = 2'h1;
	localparam logic [1:0] LRB_MODE_MUX2 = 2'h2;
	localparam logic [1:0] LRB_MODE_MUX3 = 2'h3;
	localparam logic [1:0] LRB_MODE_MUX4 = 2'h0;
	localparam logic [1:0] LRB_RST_MODE = 2'h0;
	localparam logic LRB_BIAS_HALF = 1'h1;
	localparam logic LRB_RST_BIAS = 1'h0;
	// Pointer advance per stored byte.
	localparam logic [7:0] LRB_ADV_STATIC = 8'h08;
	localparam logic [7:0] LRB_ADV_MUX2 = 8'h04;
	localparam logic [7:0] LRB_ADV_MUX3 = 8'h03;
	localparam logic [7:0] LRB_ADV_MUX4 = 8'h02;
	// Last tick count of each slot phase; each slot has two phases of four ticks.
	localparam logic [3:0] LRB_SLOT_TICKS = 4'h3;
	localparam logic [1:0] LRB_BUF_DEPTH = 2'h2;
	typedef enum logic [1:0] {LRB_ROW0, LRB_ROW1, LRB_ROW2, LRB_ROW3} lrb_row_e;
endpackage

// >>> lrb_skid_buf.sv
// Two-entry buffer for display bytes between the host interface and the memory writer.
`timescale 1ns/100ps
module lrb_skid_buf (
	// Clock, reset and enable.
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire logic ce_in,
	// Filling side.
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [15:0] in_data_in,
	// Draining side.
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [15:0] out_data_out
);
	import lrb_pkg::*;
	logic [15:0] mem_q [2];
	logic wp_q, rp_q;
	logic [1:0] cnt_q;
	wire push = ce_in && in_valid_in && (cnt_q != LRB_BUF_DEPTH);
	wire pop = ce_in && out_ready_in && (cnt_q != 2'h0);
	wire [1:0] cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
	// Full blocks the source, so a stalled writer loses no byte.
	// Ready is registered from the next count, so it always equals the not-full state of cnt_q.
	assign out_valid_out = (cnt_q != 2'h0);
	assign out_data_out = mem_q[rp_q];
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			wp_q <= 1'b0;
			rp_q <= 1'b0;
			cnt_q <= 2'h0;
			in_ready_out <= 1'b1;
		end else begin
			if (push) begin
				mem_q[wp_q] <= in_data_in;
				wp_q <= ~wp_q;
			end
			if (pop)
				rp_q <= ~rp_q;
			cnt_q <= cnt_d;
			in_ready_out <= (cnt_d != LRB_BUF_DEPTH);
		end
	end
	a_buf_no_overfill: assert property (@(posedge mclk_in) disable iff (!rstn_in) cnt_q <= LRB_BUF_DEPTH)
		else $error("buffer count above depth");
endmodule // lrb_skid_buf

// >>> lrb_mux_core.sv
// Display memory, byte scatter and multiplexed common and column sequencing.
`timescale 1ns/100ps
// Notes on behaviour
// - Memory holds 160 columns by 4 rows of single bits.
// - Stored 1 drives element on, stored 0 drives it off.
// - Rows map to common lines 0-3, columns to column lines 0-159.
// - Row k column data is shown while common line k is active.
// - Display bytes are stored on arrival, not after acknowledge.
// - Static mode writes byte into row 0 of eight columns.
// - Two-way mode writes four 2-bit column words, rows 0 and 1.
// - Three-way mode writes three 3-bit words; last row 2 bit kept.
// - Four-way mode writes two 4-bit column words, rows 0 to 3.
// - Display register holds slot column data stable during the slot.
// - Common waveforms follow the mode; four-way gives four distinct slots.
// - Three-way mode: common line 3 copies common line 1.
// - Two-way mode: line 2 copies line 0, line 3 copies line 1.
// - Static mode: all common lines carry one waveform.
// - Column waveform comes from common timing and display register data.
// - Half bias with two-way mode closes the divider bypass switch.
// - Drive-mode command sets multiplex ratio and bias for level selection.
// - Two-way mode accepts half or third bias, chosen independently.
// - Half bias also selectable in three-way and four-way modes.
// - Pointer advances 8, 4, 3 or 2 columns per stored byte.
// - Cascade mismatch suppresses the write but still advances the pointer.
// - Power-on mode is four-way multiplex with third bias.
// - Display row sequence 0-3, 0-2, 0-1 or 0 by mode.
module lrb_mux_core (
	// Clock, reset and enable.
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire logic ce_in,
	// Drive-mode configuration command.
	input wire logic cfg_we_in,
	input wire logic [1:0] cfg_mode_in,
	input wire logic cfg_bias_in,
	// Pointer load and cascade position.
	input wire logic ptr_we_in,
	input wire logic [7:0] ptr_in,
	input wire logic [1:0] sub_cnt_in,
	input wire logic cascade_position_input_0,
	input wire logic cascade_position_input_1,
	// Display byte stream.
	input wire logic byte_valid_in,
	output logic byte_ready_out,
	input wire logic [7:0] byte_in,
	// Panel drive.
	output logic common_line_0,
	output logic common_line_1,
	output logic common_line_2,
	output logic common_line_3,
	output logic [lrb_pkg::LRB_COLS-1:0] column_drive_lines,
	output logic common_level_out,
	output logic [lrb_pkg::LRB_COLS-1:0] column_level_out,
	output logic [1:0] lvl_mode_out,
	output logic bias_half_out,
	output logic bypass_sw_out,
	output logic [7:0] ptr_out,
	output logic ptr_wrap_out
);
	import lrb_pkg::*;

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic logic [7:0] adv_of(input logic [1:0] m);
		unique case (m)
			LRB_MODE_STATIC: adv_of = LRB_ADV_STATIC;
			LRB_MODE_MUX2: adv_of = LRB_ADV_MUX2;
			LRB_MODE_MUX3: adv_of = LRB_ADV_MUX3;
			LRB_MODE_MUX4: adv_of = LRB_ADV_MUX4;
		endcase
	endfunction

	function automatic logic [1:0] last_row_of(input logic [1:0] m);
		unique case (m)
			LRB_MODE_STATIC: last_row_of = 2'h0;
			LRB_MODE_MUX2: last_row_of = 2'h1;
			LRB_MODE_MUX3: last_row_of = 2'h2;
			LRB_MODE_MUX4: last_row_of = 2'h3;
		endcase
	endfunction

	// ----------------------------------------
	// Configuration
	// ----------------------------------------
	logic [1:0] mode_q;
	logic bias_q;
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			mode_q <= LRB_RST_MODE;
			bias_q <= LRB_RST_BIAS;
		end else if (ce_in && cfg_we_in) begin
			// Half bias in any multiplex mode.
			mode_q <= cfg_mode_in;
			bias_q <= cfg_bias_in;
		end
	end

	// ----------------------------------------
	// Byte buffer and scatter writer
	// ----------------------------------------
	wire b_valid;
	wire [15:0] b_data;
	logic b_ready;
	lrb_skid_buf u_buf (
		.mclk_in(mclk_in),
		.rstn_in(rstn_in),
		.ce_in(ce_in),
		.in_valid_in(byte_valid_in),
		.in_ready_out(byte_ready_out),
		.in_data_in({sub_cnt_in, 6'h00, byte_in}),
		.out_valid_out(b_valid),
		.out_ready_in(b_ready),
		.out_data_out(b_data)
	);

	logic ram_q [LRB_COLS][LRB_ROWS];
	logic [7:0] ptr_q;
	logic wrap_q;
	// Pointer loads take precedence, so a byte waits for as long as ptr_we_in is held.
	assign b_ready = !ptr_we_in;
	wire take = ce_in && b_valid && b_ready;
	wire [1:0] hw_sub = {cascade_position_input_1, cascade_position_input_0};
	// Storage enabled only on a cascade position match.
	wire sub_ok = (b_data[15:14] == hw_sub);
	wire [1:0] last_row = last_row_of(mode_q);
	wire [2:0] rows_per = {1'b0, last_row} + 3'h1;
	wire [8:0] ptr_sum = {1'b0, ptr_q} + {1'b0, adv_of(mode_q)};

	// Bit i of the byte, MSB first, lands at column ptr + i / rows, row i % rows.
	logic wr_en [8];
	logic [7:0] wr_col [8];
	logic [1:0] wr_row [8];
	logic wr_row3;
	always_comb begin
		wr_row3 = 1'b0;
		for (int i = 0; i < 8; i++) begin
			wr_row[i] = 2'((i[2:0]) % rows_per);
			wr_col[i] = ptr_q + 8'((i[2:0]) / rows_per);
			// Third column row 2 is left untouched.
			// Only rows within the active count are written.
			wr_en[i] = take && sub_ok && (wr_col[i] <= LRB_LAST_COL)
				&& (wr_row[i] <= last_row);
			wr_row3 = wr_row3 | (wr_en[i] && wr_row[i] == 2'h3);
		end
	end

	// ----------------------------------------
	// Write pointer
	// ----------------------------------------
	// The pointer moves even on a cascade mismatch, so every driver of a chain stays in step.
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			ptr_q <= 8'h00;
			wrap_q <= 1'b0;
		end else if (ce_in) begin
			if (ptr_we_in) begin
				ptr_q <= ptr_in;
				wrap_q <= 1'b0;
			end else if (take) begin
				// Advance by mode, wrap past the last column.
				ptr_q <= (ptr_sum > {1'b0, LRB_LAST_COL}) ? 8'(ptr_sum - 9'(LRB_COLS)) : ptr_sum[7:0];
				wrap_q <= (ptr_sum > {1'b0, LRB_LAST_COL});
			end else begin
				wrap_q <= 1'b0;
			end
		end
	end

	// Flip-flop bitmap, written straight from the arriving byte.
	// No acknowledge wait.
	// Cleared at reset so that unwritten elements show off rather than an unknown level.
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			for (int c = 0; c < LRB_COLS; c++)
				for (int k = 0; k < LRB_ROWS; k++)
					ram_q[c][k] <= 1'b0;
		end else begin
			for (int i = 0; i < 8; i++)
				if (wr_en[i])
					ram_q[wr_col[i]][wr_row[i]] <= b_data[7 - i];
		end
	end

	// ----------------------------------------
	// Multiplex sequencer
	// ----------------------------------------
	logic [3:0] tick_q;
	logic phase_q;
	lrb_row_e row_q;
	wire slot_end = (tick_q == LRB_SLOT_TICKS) && phase_q;
	wire [1:0] row_next = (row_q >= last_row) ? 2'h0 : 2'(row_q + 2'h1);
	wire [1:0] load_row = slot_end ? row_next : 2'(row_q);

	logic [LRB_COLS-1:0] disp_q;
	logic [LRB_COLS-1:0] slot_data;
	always_comb begin
		for (int c = 0; c < LRB_COLS; c++)
			// Column c drives column line c.
			slot_data[c] = ram_q[c][load_row];
	end

	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			tick_q <= 4'h0;
			phase_q <= 1'b0;
			row_q <= LRB_ROW0;
			disp_q <= '0;
		end else if (ce_in) begin
			tick_q <= (tick_q == LRB_SLOT_TICKS) ? 4'h0 : 4'(tick_q + 4'h1);
			if (tick_q == LRB_SLOT_TICKS)
				phase_q <= ~phase_q;
			if (slot_end) begin
				row_q <= lrb_row_e'(row_next);
				// Display register reloaded only at slot boundaries.
				// Row k data aligned to slot k.
				disp_q <= slot_data;
			end
		end
	end

	// Common select: a common line is selected when its slot is active.
	// Per-mode common pattern.
	// Duplicated lines by mode.
	// A row left over from a wider mode selects no three-way common until the next slot.
	wire [1:0] r = row_q;
	wire [3:0] sel = (mode_q == LRB_MODE_STATIC) ? 4'hf :
		(mode_q == LRB_MODE_MUX2) ? (r[0] ? 4'ha : 4'h5) :
		(mode_q == LRB_MODE_MUX3) ? ((r == 2'h1) ? 4'ha : ((4'h1 << r) & 4'h5)) :
		(4'h1 << r);
	// Selected commons swing opposite to the phase; others sit at a mid level.
	wire com_pol = ~phase_q;
	// On elements drive opposite to the common, off follow it.
	wire [LRB_COLS-1:0] col_pol = {LRB_COLS{phase_q}} ^ ~disp_q;
	wire bypass_d = bias_q && (mode_q == LRB_MODE_MUX2);

	// ----------------------------------------
	// Panel drive outputs
	// ----------------------------------------
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			{common_line_3, common_line_2, common_line_1, common_line_0} <= 4'h0;
			column_drive_lines <= '0;
			common_level_out <= 1'b0;
			column_level_out <= '0;
			lvl_mode_out <= LRB_RST_MODE;
			bias_half_out <= LRB_RST_BIAS;
			bypass_sw_out <= 1'b0;
			ptr_out <= 8'h00;
			ptr_wrap_out <= 1'b0;
		end else if (ce_in) begin
			{common_line_3, common_line_2, common_line_1, common_line_0} <= sel;
			column_drive_lines <= disp_q;
			common_level_out <= com_pol;
			column_level_out <= col_pol;
			lvl_mode_out <= mode_q;
			bias_half_out <= bias_q;
			bypass_sw_out <= bypass_d;
			ptr_out <= ptr_q;
			ptr_wrap_out <= wrap_q;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_slot_end;
		ce_in && slot_end;
	endsequence
	a_bypass_rule: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		ce_in |=> bypass_sw_out == $past(bias_q && mode_q == LRB_MODE_MUX2)) else $error("bypass switch wrong");
	a_mux3_dup_line: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		$past(ce_in && mode_q == LRB_MODE_MUX3) |-> common_line_3 == common_line_1) else $error("line 3 not copy of 1");
	a_mux2_dup_lines: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		$past(ce_in && mode_q == LRB_MODE_MUX2) |-> common_line_2 == common_line_0 && common_line_3 == common_line_1)
		else $error("two-way duplicates wrong");
	a_static_all_same: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		$past(ce_in && mode_q == LRB_MODE_STATIC) |-> common_line_0 && common_line_1 && common_line_2 && common_line_3)
		else $error("static commons differ");
	a_row_in_range: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		s_slot_end ##0 !cfg_we_in |=> 2'(row_q) <= last_row) else $error("row beyond active count");
	a_disp_stable: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		!(ce_in && slot_end) |=> $stable(disp_q))
		else $error("display register moved mid slot");
	a_ptr_advance: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		take && !ptr_we_in && ptr_sum <= 9'd159 |=> ptr_q == $past(ptr_sum[7:0])) else $error("pointer advance wrong");
	a_no_store_mism: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		take && !sub_ok |-> !wr_en[0] && !wr_en[7]) else $error("write on cascade mismatch");
	a_reset_mode: assert property (@(posedge mclk_in)
		!rstn_in |=> mode_q == LRB_MODE_MUX4 && bias_q == 1'b0) else $error("reset mode wrong");

	// ----------------------------------------
	// Configuration, writer and pointer checks
	// ----------------------------------------
	sequence s_cfg_load;
		ce_in && cfg_we_in;
	endsequence
	sequence s_wrap_take;
		take && (ptr_sum > {1'b0, LRB_LAST_COL});
	endsequence
	a_cfg_load: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		s_cfg_load |=> mode_q == $past(cfg_mode_in) && bias_q == $past(cfg_bias_in))
		else $error("drive mode not loaded");
	a_ptr_load: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		ce_in && ptr_we_in |=> ptr_q == $past(ptr_in))
		else $error("pointer not loaded");
	a_wrap_pulse: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		s_wrap_take ##1 ce_in |=> ptr_wrap_out)
		else $error("wrap pulse missing");
	a_wrap_single: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		ptr_wrap_out && ce_in |=> !ptr_wrap_out)
		else $error("wrap pulse too long");
	a_mux3_no_row3: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		mode_q == LRB_MODE_MUX3 |-> !wr_row3)
		else $error("row 3 written in three-way mode");

	// ----------------------------------------
	// Panel drive checks
	// ----------------------------------------
	a_mux4_one_hot: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		$past(ce_in && rstn_in && mode_q == LRB_MODE_MUX4)
		|-> $onehot({common_line_3, common_line_2, common_line_1, common_line_0}))
		else $error("four-way commons not one-hot");
	a_column_level: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		column_level_out == ({LRB_COLS{common_level_out}} ^ column_drive_lines))
		else $error("column level does not follow data");
	a_static_row0: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		s_slot_end ##0 (mode_q == LRB_MODE_STATIC && !cfg_we_in) |=> row_q == LRB_ROW0)
		else $error("static mode left row 0");
	a_cols_track: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		$changed(column_drive_lines) |-> $past(ce_in) && column_drive_lines == $past(disp_q))
		else $error("column lines not from display register");
endmodule // lrb_mux_core

// >>> lrb_panel_model.sv
// Panel model that latches the column pattern seen under each common line.
`timescale 1ns/100ps
module lrb_panel_model (
	// Drive from the block.
	input wire logic mclk_in,
	input wire logic [3:0] common_in,
	input wire logic [159:0] column_in,
	// Column pattern seen per common line.
	output logic [159:0] cap_out [4]
);
	logic [3:0] run_q [4];
	// ---------------------------------------------
	// Latching
	// ---------------------------------------------
	// sample mid slot.
	// Sampling mid slot keeps clear of the edge where columns and commons change together.
	always_ff @(posedge mclk_in) begin
		for (int k = 0; k < 4; k++) begin
			run_q[k] <= common_in[k] ? run_q[k] + 4'h1 : 4'h0;
			if (common_in[k] && run_q[k] == 4'h3) begin
				cap_out[k] <= column_in;
			end
		end
	end
endmodule // lrb_panel_model

// >>> lcd_ram_backplane_mux_tb_top.sv
// Self-checking testbench for the display memory and multiplex drive block.
`timescale 1ns/100ps
module lcd_ram_backplane_mux_tb_top;
	import lrb_pkg::*;
	logic mclk_in = 0, rstn_in = 0, cfg_we_in = 0, cfg_bias_in = 0, ptr_we_in = 0, byte_valid_in = 0, ce_in = 1;
	logic [1:0] cfg_mode_in = 0, sub_cnt_in = 0;
	logic [7:0] ptr_in = 0, byte_in = 0;
	wire [3:0] cl;
	wire [159:0] cols, col_lvl;
	wire [1:0] lvl_mode;
	wire [7:0] ptr_out;
	wire rdy, c_lvl, bias_half, bypass, wrap;
	logic [159:0] cap [4];
	logic wrap_seen = 0;
	int fail_count = 0, cmp_count = 0;
	always #5 mclk_in = ~mclk_in;
	always @(negedge mclk_in) if (wrap === 1'b1) wrap_seen = 1'b1;
	lrb_mux_core u_lrb_mux_core (.mclk_in(mclk_in), .rstn_in(rstn_in), .ce_in(ce_in), .cfg_we_in(cfg_we_in),
		.cfg_mode_in(cfg_mode_in), .cfg_bias_in(cfg_bias_in), .ptr_we_in(ptr_we_in), .ptr_in(ptr_in),
		.sub_cnt_in(sub_cnt_in), .cascade_position_input_0(1'b0), .cascade_position_input_1(1'b0),
		.byte_valid_in(byte_valid_in), .byte_ready_out(rdy), .byte_in(byte_in), .common_line_0(cl[0]),
		.common_line_1(cl[1]), .common_line_2(cl[2]), .common_line_3(cl[3]), .column_drive_lines(cols),
		.common_level_out(c_lvl), .column_level_out(col_lvl), .lvl_mode_out(lvl_mode),
		.bias_half_out(bias_half), .bypass_sw_out(bypass), .ptr_out(ptr_out), .ptr_wrap_out(wrap));
	lrb_panel_model u_lrb_panel_model (.mclk_in(mclk_in), .common_in(cl), .column_in(cols), .cap_out(cap));
	// ---------------------------------------------
	// Shared tasks
	// ---------------------------------------------
	task chk(input string nm, input logic [159:0] seen, input logic [159:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task results();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(negedge mclk_in);
	endtask
	task cfg(input logic [1:0] m, input logic b);
		@(negedge mclk_in) cfg_we_in = 1; cfg_mode_in = m; cfg_bias_in = b;
		@(negedge mclk_in) cfg_we_in = 0;
		cyc(2);
	endtask
	task ld(input logic [7:0] p);
		@(negedge mclk_in) ptr_we_in = 1; ptr_in = p;
		@(negedge mclk_in) ptr_we_in = 0;
	endtask
	// Ready is read at the falling edge, so the next rising edge takes the byte.
	task send(input logic [7:0] b);
		int n;
		n = 0;
		@(negedge mclk_in) byte_valid_in = 1; byte_in = b;
		while (rdy !== 1'b1 && n < 50) begin
			n++;
			@(negedge mclk_in);
		end
		chk("ready", rdy, 1'b1);
		@(posedge mclk_in);
	endtask
	task idle();
		@(negedge mclk_in) byte_valid_in = 0;
		cyc(6);
	endtask
	task watch(input int m);
		int bad;
		bad = 0;
		repeat (40) begin
			@(negedge mclk_in);
			if (m == 0 && $countones(cl) > 1) bad++;
			if (m == 1 && (cl[1] !== cl[0] || cl[2] !== cl[0] || cl[3] !== cl[0])) bad++;
			if (m == 2 && (cl[2] !== cl[0] || cl[3] !== cl[1])) bad++;
			if (m == 3 && cl[3] !== cl[1]) bad++;
		end
		chk("commons", bad, 0);
	endtask
	// ---------------------------------------------
	// Scenarios
	// ---------------------------------------------
	task t_mux4();
		ld(8'h00); send(8'ha5); idle();
		chk("ptr", ptr_out, 8'h02);
		ld(8'h20); send(8'hff); send(8'hff); idle();
		chk("ptr", ptr_out, 8'h24);
		cyc(80);
		for (int k = 0; k < 4; k++) chk("row", cap[k][1:0], (k % 2) ? 2'b10 : 2'b01);
		chk("row3", cap[3][35:32], 4'hf);
		chk("level", col_lvl, {160{c_lvl}} ^ cols);
		watch(0);
	endtask
	task t_mux2();
		cfg(LRB_MODE_MUX2, 1'b0);
		chk("bypass", bypass, 0);
		cfg(LRB_MODE_MUX2, 1'b1);
		chk("bypass", bypass, 1);
		chk("mode", lvl_mode, LRB_MODE_MUX2);
		ld(8'h10); send(8'hc6); idle();
		chk("ptr", ptr_out, 8'h14);
		cyc(80);
		chk("row0", cap[0][19:16], 4'b1001);
		chk("row1", cap[1][19:16], 4'b0101);
		watch(2);
	endtask
	task t_mux3();
		cfg(LRB_MODE_MUX3, 1'b1);
		chk("bypass", bypass, 0);
		chk("bias", bias_half, 1);
		ld(8'h20); send(8'h00); idle();
		chk("ptr", ptr_out, 8'h23);
		cyc(80);
		chk("row2", cap[2][35:32], 4'b1100);
		chk("row0", cap[0][35:32], 4'b1000);
		chk("row3", cap[3][35:32], 4'b1000);
		watch(3);
		sub_cnt_in = 2'h1;
		ld(8'h20); send(8'hff); idle();
		sub_cnt_in = 2'h0;
		chk("ptr", ptr_out, 8'h23);
		cyc(80);
		chk("row0", cap[0][35:32], 4'b1000);
	endtask
	task t_static();
		cfg(LRB_MODE_STATIC, 1'b0);
		ld(8'h40); send(8'h82); idle();
		chk("ptr", ptr_out, 8'h48);
		cyc(80);
		chk("row0", cap[0][71:64], 8'h41);
		chk("cols", cols[71:64], 8'h41);
		watch(1);
	endtask
	task t_wrap_buf();
		cfg(LRB_MODE_MUX4, 1'b0);
		wrap_seen = 0;
		ld(8'h9e); send(8'h3c); idle();
		chk("ptr", ptr_out, 8'h00);
		chk("wrap", wrap_seen, 1);
		@(negedge mclk_in) ptr_we_in = 1; ptr_in = 8'h50;
		send(8'h11); send(8'h22);
		@(negedge mclk_in) byte_valid_in = 0;
		chk("ready", rdy, 0);
		ptr_we_in = 0;
		cyc(8);
		chk("ptr", ptr_out, 8'h54);
		chk("ready", rdy, 1);
	endtask
	task t_freeze();
		@(negedge mclk_in) ce_in = 0; ptr_we_in = 1; ptr_in = 8'h77;
		cyc(4);
		chk("frozen ptr", ptr_out, 8'h54);
		@(negedge mclk_in) ptr_we_in = 0; ce_in = 1;
		cyc(2);
		chk("ptr", ptr_out, 8'h54);
	endtask
	initial begin
		#100000;
		fail_count++;
		results();
	end
	initial begin
		repeat (8) @(negedge mclk_in);
		rstn_in = 1;
		cyc(2);
		chk("mode", lvl_mode, LRB_RST_MODE);
		chk("bias", bias_half, LRB_RST_BIAS);
		t_mux4();
		t_mux2();
		t_mux3();
		t_static();
		t_wrap_buf();
		t_freeze();
		results();
	end
endmodule // lcd_ram_backplane_mux_tb_top
